// ===== include/io_ports_pkg.sv
// Shared constants and types for the four-port I/O block: three quasi-bidirectional ports and one true bidirectional port.
// Assumes a single core clock; all port-register accesses come from the core as strobes.
package io_ports_pkg;

    // ------------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------------
    localparam int          PORT_W        = 8;
    localparam int          NUM_PORTS     = 4;
    localparam int          SEL_W         = 2;
    localparam int          BIT_SEL_W     = 3;

    // Port indices: low-address port, alternate port A, upper-address port, alternate port B.
    localparam logic [1:0]  PORT_LOW_ADDR = 2'h0;
    localparam logic [1:0]  PORT_ALT_A    = 2'h1;
    localparam logic [1:0]  PORT_HIGH_ADR = 2'h2;
    localparam logic [1:0]  PORT_ALT_B    = 2'h3;

    // Pin positions used by extended address bits and the data read strobe.
    localparam int          A17_BIT_POS   = 7;
    localparam int          A16_BIT_POS   = 7;

    // ------------------------------------------------------------------
    // Latch values loaded at reset and during bus cycles
    // ------------------------------------------------------------------
    localparam logic [7:0]  LATCH_RST     = 8'hff;
    localparam logic [7:0]  BUS_LATCH_VAL = 8'hff;

    // ------------------------------------------------------------------
    // Strong pull-up pulse: two oscillator periods at 40 ns each
    // ------------------------------------------------------------------
    localparam int          CLK_PERIOD_NS = 40;
    localparam int          PULLUP_TIME_NS = 80;
    localparam int          PULLUP_CYCLES = (PULLUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0]  PULLUP_CNT_LD = 2'(PULLUP_CYCLES);

    // ------------------------------------------------------------------
    // Read-modify-write operations applied to a latch value
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_AND, OP_OR, OP_XOR, OP_INC, OP_DEC, OP_CPL_BIT, OP_JBC_BIT,
        OP_SET_BIT, OP_CLR_BIT, OP_MOV_CARRY, OP_CPL_BYTE
    } rmw_op_t;

    // Read strobe selection for external data reads.
    localparam logic [1:0]  RDSEL_PROG    = 2'h0;

    // External bus cycle phases.
    typedef enum logic [1:0] {
        BUS_IDLE, BUS_ADDR, BUS_WRITE, BUS_READ
    } bus_phase_t;

endpackage : io_ports_pkg

// ===== hw/pullup_pulse.sv
// One strong pull-up pulse generator per latch bit of the three quasi-bidirectional ports.
// Assumes the latch value is presented as a registered signal in the same clock domain.
`timescale 1ns/1ns
module pullup_pulse (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       clk_en,
    // Latch bit and pulse output
    input  wire logic       latch_bit,
    output logic            pullup_en
);
    import io_ports_pkg::*;

    logic       prev_q;
    logic [1:0] cnt_q;
    logic       rise;

    // A zero-to-one change in the latch starts the pulse.
    assign rise = latch_bit & ~prev_q;

    // Counter holds the pulse for exactly the loaded number of cycles; a new
    // rise restarts it so overlapping transitions never shorten the pulse.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_q    <= 1'b1;
            cnt_q     <= 2'h0;
            pullup_en <= 1'b0;
        end else if (clk_en) begin
            prev_q <= latch_bit;
            if (rise) begin
                cnt_q     <= PULLUP_CNT_LD - 2'h1;
                pullup_en <= 1'b1;
            end else if (cnt_q != 2'h0) begin
                cnt_q     <= cnt_q - 2'h1;
                pullup_en <= 1'b1;
            end else begin
                pullup_en <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_pulse_len;
        @(posedge clk) disable iff (!rst_b)
        (clk_en && rise) ##1 clk_en |-> pullup_en ##1 (clk_en [*1]) |-> pullup_en;
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("pull-up pulse too short");

endmodule : pullup_pulse

// ===== hw/io_ports.sv
// Four 8-bit port latches with pin read paths, read-modify-write logic,
// pin drivers and the multiplexed external address/data bus takeover.
// Assumes the core issues one port access per cycle as strobes and that pins
// are resolved outside from the output and output-enable pairs.
`timescale 1ns/1ns
module io_ports (
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         rst_b,
    input  wire logic                         clk_en,
    // Core port access
    input  wire logic [io_ports_pkg::SEL_W-1:0]     port_sel,
    input  wire logic                         port_wr,
    input  wire logic [7:0]                   port_wdata,
    input  wire logic                         rmw_en,
    input  wire io_ports_pkg::rmw_op_t        rmw_op,
    input  wire logic [7:0]                   rmw_operand,
    input  wire logic [io_ports_pkg::BIT_SEL_W-1:0] rmw_bit,
    input  wire logic                         rmw_carry,
    input  wire logic                         read_pin_sel,
    output logic [7:0]                        port_rdata,
    output logic                              rmw_bit_old,
    // External bus control
    input  wire logic                         bus_active,
    input  wire io_ports_pkg::bus_phase_t     bus_phase,
    input  wire logic                         bus_page_mode,
    input  wire logic                         bus_prog_fetch,
    input  wire logic [1:0]                   read_strobe_select_cfg,
    input  wire logic [1:0]                   addr_width_sel,
    input  wire logic [17:0]                  bus_addr,
    input  wire logic [7:0]                   bus_wdata,
    output logic [7:0]                        bus_rdata,
    output logic                              program_read_strobe_n,
    output logic                              data_read_strobe_n,
    // Alternate functions on the two general ports
    input  wire logic [7:0]                   alt_out_a,
    input  wire logic [7:0]                   alt_out_b,
    // Pins
    input  wire logic [31:0]                  pin_in,
    output logic [31:0]                       pin_out,
    output logic [31:0]                       pin_oe,
    output logic [31:0]                       strong_pullup
);
    import io_ports_pkg::*;

    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] bit_mask(input logic [2:0] b);
        bit_mask = 8'h01 << b;
    endfunction : bit_mask

    function automatic logic [7:0] rmw_result(input rmw_op_t op, input logic [7:0] v,
                                              input logic [7:0] opd, input logic [2:0] b,
                                              input logic c);
        logic [7:0] m;
        m = bit_mask(b);
        case (op)
            OP_AND:       rmw_result = v & opd;
            OP_OR:        rmw_result = v | opd;
            OP_XOR:       rmw_result = v ^ opd;
            OP_INC:       rmw_result = v + 8'h01;
            OP_DEC:       rmw_result = v - 8'h01;
            OP_CPL_BIT:   rmw_result = v ^ m;
            OP_JBC_BIT:   rmw_result = v & ~m;
            OP_SET_BIT:   rmw_result = v | m;
            OP_CLR_BIT:   rmw_result = v & ~m;
            OP_MOV_CARRY: rmw_result = c ? (v | m) : (v & ~m);
            OP_CPL_BYTE:  rmw_result = ~v;
            default:      rmw_result = v;
        endcase
    endfunction : rmw_result

    // ------------------------------------------------------------------
    // Latches, synchroniser and registered pin drive
    // ------------------------------------------------------------------
    logic [7:0]  port_latch_register [NUM_PORTS];
    logic [31:0] sync1_q;
    logic [31:0] sync2_q;
    logic [7:0]  latch_sel;
    logic [7:0]  pin_sel;
    logic [7:0]  rmw_val;
    logic        bus_cyc;
    logic        data_on_high;
    logic        data_on_low;
    logic        reading;
    logic [7:0]  low_addr_data_bus;
    logic [7:0]  high_addr_bus;
    logic        addr_bit_sixteen;
    logic        addr_bit_seventeen;
    logic [7:0]  low_drv;
    logic [7:0]  low_oe;
    logic [7:0]  high_drv;
    logic [7:0]  high_oe;
    logic [7:0]  a_drv;
    logic [7:0]  b_drv;
    logic        ext_wide;
    logic        ext_16;
    logic        data_rd;
    logic [31:0] latch_flat;

    // Selected latch and selected synchronised pin byte.
    assign latch_sel = port_latch_register[port_sel];
    assign pin_sel   = sync2_q[8*port_sel +: 8];
    // Read-modify-write always works from the latch, never the pin.
    assign rmw_val   = rmw_result(rmw_op, latch_sel, rmw_operand, rmw_bit, rmw_carry);

    // Bus phase decoding.
    assign bus_cyc      = bus_active && (bus_phase != BUS_IDLE);
    assign data_on_high = bus_page_mode;
    assign data_on_low  = !bus_page_mode;
    assign reading      = bus_cyc && (bus_phase == BUS_READ);
    assign ext_wide     = addr_width_sel[1];
    assign ext_16       = (addr_width_sel != 2'h0);

    // Address byte routing; data replaces the address byte in write phases.
    assign low_addr_data_bus = (data_on_low && bus_phase == BUS_WRITE) ? bus_wdata
                               : bus_addr[7:0];
    assign high_addr_bus     = (data_on_high && bus_phase == BUS_WRITE) ? bus_wdata
                               : bus_addr[15:8];
    assign addr_bit_sixteen   = bus_addr[16];
    assign addr_bit_seventeen = bus_addr[17];

    // Low-address port: bus drives both levels; otherwise open drain (zeros only).
    assign low_drv = bus_cyc ? low_addr_data_bus : 8'h00;
    assign low_oe  = bus_cyc ? ((data_on_low && reading) ? 8'h00 : 8'hff)
                             : ~port_latch_register[PORT_LOW_ADDR];
    // Upper port: only used by the bus for 16-bit and wider cycles, else latch bits.
    assign high_drv = (bus_cyc && ext_16) ? high_addr_bus
                                          : port_latch_register[PORT_HIGH_ADR];
    assign high_oe  = (bus_cyc && ext_16) ? ((data_on_high && reading) ? 8'h00 : 8'hff)
                                          : ~port_latch_register[PORT_HIGH_ADR];
    // Alternate ports: latch one hands the pin to the alternate output.
    assign a_drv = port_latch_register[PORT_ALT_A] & alt_out_a;
    assign b_drv = port_latch_register[PORT_ALT_B] & alt_out_b;
    // Data reads pick the program or the data strobe; fetches use the program strobe.
    assign data_rd = reading && !bus_prog_fetch && (read_strobe_select_cfg != RDSEL_PROG);

    // Latch writes; a bus cycle forces the low-address latch to ones.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_PORTS; i++) begin
                port_latch_register[i] <= LATCH_RST;
            end
        end else if (clk_en) begin
            if (rmw_en) begin
                port_latch_register[port_sel] <= rmw_val;
            end else if (port_wr) begin
                port_latch_register[port_sel] <= port_wdata;
            end
            if (bus_cyc) begin
                port_latch_register[PORT_LOW_ADDR] <= BUS_LATCH_VAL;
            end
        end
    end

    // Two-flop pin synchroniser; only the second stage is ever read.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_q <= '1;
            sync2_q <= '1;
        end else if (clk_en) begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
        end
    end

    // Read data and the old bit value for jbc-style tests.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            port_rdata  <= 8'hff;
            rmw_bit_old <= 1'b1;
            bus_rdata   <= 8'h00;
        end else if (clk_en) begin
            port_rdata  <= read_pin_sel ? pin_sel : latch_sel;
            rmw_bit_old <= latch_sel[rmw_bit];
            if (reading) begin
                bus_rdata <= data_on_low ? sync2_q[7:0] : sync2_q[23:16];
            end
        end
    end

    // Pin drive registers: pins follow the latch one cycle after it changes, so a
    // modified value reaches the pins early in the next operation.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_out               <= '1;
            pin_oe                <= '0;
            program_read_strobe_n <= 1'b1;
            data_read_strobe_n    <= 1'b1;
        end else if (clk_en) begin
            pin_out[7:0]   <= low_drv;
            pin_oe[7:0]    <= low_oe;
            pin_out[15:8]  <= a_drv;
            pin_oe[15:8]   <= ~a_drv;
            pin_out[23:16] <= high_drv;
            pin_oe[23:16]  <= high_oe;
            pin_out[31:24] <= b_drv;
            pin_oe[31:24]  <= ~b_drv;
            // Extended address bits take over bit 7 of the alternate ports.
            if (bus_cyc && ext_wide) begin
                pin_out[8+A17_BIT_POS]  <= addr_bit_seventeen;
                pin_oe[8+A17_BIT_POS]   <= 1'b1;
                pin_out[24+A16_BIT_POS] <= addr_bit_sixteen;
                pin_oe[24+A16_BIT_POS]  <= 1'b1;
            end else if (bus_cyc) begin
                pin_out[24+A16_BIT_POS] <= !data_rd;
                pin_oe[24+A16_BIT_POS]  <= 1'b1;
            end
            program_read_strobe_n <= !(reading && !data_rd);
            data_read_strobe_n    <= !data_rd;
        end
    end

    // ------------------------------------------------------------------
    // Strong pull-up on the three quasi-bidirectional ports
    // ------------------------------------------------------------------
    assign latch_flat = {port_latch_register[3], port_latch_register[2],
                         port_latch_register[1], port_latch_register[0]};
    assign strong_pullup[7:0] = 8'h00;  // The true bidirectional port has no pull-up.

    genvar g;
    generate
        for (g = 8; g < 32; g++) begin : g_pu
            pullup_pulse u_pu (
                .clk       (clk),
                .rst_b     (rst_b),
                .clk_en    (clk_en),
                .latch_bit (latch_flat[g]),
                .pullup_en (strong_pullup[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_bus_ones;
        @(posedge clk) disable iff (!rst_b)
        (clk_en && bus_cyc) |=> (port_latch_register[PORT_LOW_ADDR] == 8'hff);
    endproperty
    a_bus_ones: assert property (p_bus_ones) else $error("low latch not ones");

    property p_high_kept;
        @(posedge clk) disable iff (!rst_b)
        (clk_en && bus_cyc && !port_wr && !rmw_en)
            |=> $stable(port_latch_register[PORT_HIGH_ADR]);
    endproperty
    a_high_kept: assert property (p_high_kept) else $error("upper latch changed");

    property p_write;
        @(posedge clk) disable iff (!rst_b)
        (clk_en && port_wr && !rmw_en && port_sel == PORT_ALT_A)
            |=> (port_latch_register[PORT_ALT_A] == $past(port_wdata));
    endproperty
    a_write: assert property (p_write) else $error("latch write lost");

    property p_read_latch;
        @(posedge clk) disable iff (!rst_b)
        (clk_en && !read_pin_sel && !port_wr && !rmw_en && !bus_cyc)
            |=> (port_rdata == $past(latch_sel));
    endproperty
    a_read_latch: assert property (p_read_latch) else $error("latch read wrong");

    property p_set_bit;
        @(posedge clk) disable iff (!rst_b)
        (clk_en && rmw_en && rmw_op == OP_SET_BIT && port_sel == PORT_ALT_A)
            |=> (port_latch_register[PORT_ALT_A]
                 == ($past(latch_sel) | bit_mask($past(rmw_bit))));
    endproperty
    a_set_bit: assert property (p_set_bit) else $error("bit set wrong");

    property p_hiz_read;
        @(posedge clk) disable iff (!rst_b)
        (clk_en && reading && data_on_low) |=> (pin_oe[7:0] == 8'h00);
    endproperty
    a_hiz_read: assert property (p_hiz_read) else $error("low port drove on read");

    property p_open_drain;
        @(posedge clk) disable iff (!rst_b)
        (clk_en && !bus_cyc) |=> ((pin_out[7:0] & pin_oe[7:0]) == 8'h00);
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("low port drove one");

    property p_one_release;
        @(posedge clk) disable iff (!rst_b)
        (clk_en && port_latch_register[PORT_ALT_A][0] && alt_out_a[0])
            |=> !pin_oe[8];
    endproperty
    a_one_release: assert property (p_one_release) else $error("driver on with one");

    property p_pin_follow;
        @(posedge clk) disable iff (!rst_b)
        (clk_en && port_wr && !rmw_en && port_sel == PORT_HIGH_ADR && !bus_cyc)
            ##1 (clk_en && !bus_cyc) |=> (pin_out[23:16] == $past(port_wdata, 2));
    endproperty
    a_pin_follow: assert property (p_pin_follow) else $error("upper pins lag latch");

    property p_addr_nonpage;
        @(posedge clk) disable iff (!rst_b)
        (clk_en && bus_cyc && ext_16 && !bus_page_mode && bus_phase == BUS_ADDR)
            |=> (pin_out[23:16] == $past(bus_addr[15:8])
                 && pin_out[7:0] == $past(bus_addr[7:0]));
    endproperty
    a_addr_nonpage: assert property (p_addr_nonpage) else $error("nonpage address wrong");

    property p_data_page;
        @(posedge clk) disable iff (!rst_b)
        (clk_en && bus_cyc && ext_16 && bus_page_mode && bus_phase == BUS_WRITE)
            |=> (pin_out[23:16] == $past(bus_wdata)
                 && pin_out[7:0] == $past(bus_addr[7:0]));
    endproperty
    a_data_page: assert property (p_data_page) else $error("page data placement wrong");

    property p_fetch_strobe;
        @(posedge clk) disable iff (!rst_b)
        (clk_en && reading && bus_prog_fetch) |=> (!program_read_strobe_n && data_read_strobe_n);
    endproperty
    a_fetch_strobe: assert property (p_fetch_strobe) else $error("fetch used data strobe");

    property p_wide_addr;
        @(posedge clk) disable iff (!rst_b)
        (clk_en && bus_cyc && ext_wide)
            |=> (pin_out[8+A17_BIT_POS] == $past(bus_addr[17])
                 && pin_out[24+A16_BIT_POS] == $past(bus_addr[16]));
    endproperty
    a_wide_addr: assert property (p_wide_addr) else $error("extended address bit wrong");

endmodule : io_ports

// ===== bench/pin_partner.sv
// Model of the board around the four ports: pull-ups and devices that may pull pins low.
// Assumes the design drives pins as output and output-enable pairs on the same clock.
`timescale 1ns/1ns
module pin_partner (
    // Clock
    input  wire logic        clk,
    // Design drive and board pull-downs
    input  wire logic [31:0] pin_out,
    input  wire logic [31:0] pin_oe,
    input  wire logic [31:0] ext_low,
    // Resolved pin levels
    output logic [31:0]      pin_in
);
    logic tgl = 1'b0;

    // The low port has no pull-up, so a floating pin shows a changing level, never a held one.
    always @(posedge clk) begin
        tgl <= ~tgl;
    end

    // Resolve each wire from the driver, board pull-downs and pull-ups.
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            if (pin_oe[i]) begin
                pin_in[i] = pin_out[i];
            end else if (ext_low[i]) begin
                pin_in[i] = 1'b0;
            end else begin
                pin_in[i] = (i < 8) ? tgl : 1'b1;
            end
        end
    end
endmodule : pin_partner

// ===== bench/tb.sv
// Self-checking bench for the port block: latches, read paths, bus takeover.
// Assumes the pin model resolves pins and inputs change 2 ns after each rising edge.
`timescale 1ns/1ns
module tb;
    import io_ports_pkg::*;
    logic clk = 0, rst_b = 0, port_wr = 0, rmw_en = 0, rmw_carry = 0, read_pin_sel = 0;
    logic bus_active = 0, bus_page_mode = 0, rmw_bit_old, prs_n, drs_n;
    logic clk_en = 1, prog_fetch = 0;
    logic [1:0] port_sel = 0, addr_width_sel = 0;
    logic [2:0] rmw_bit = 0;
    logic [7:0] port_wdata = 0, rmw_operand = 0, port_rdata, bus_rdata, alt_out_a = 8'hff;
    logic [17:0] bus_addr = 0;
    logic [31:0] pin_in, pin_out, pin_oe, strong_pullup, ext_low = 0;
    rmw_op_t rmw_op = OP_AND;
    bus_phase_t bus_phase = BUS_IDLE;
    int fails = 0, n_checks = 0, cyc = 0;
    rmw_op_t ops[11] = '{OP_AND, OP_SET_BIT, OP_CLR_BIT, OP_MOV_CARRY, OP_OR, OP_XOR,
                         OP_INC, OP_DEC, OP_CPL_BYTE, OP_CPL_BIT, OP_JBC_BIT};
    logic [7:0] opd[11] = '{8'h0f, 0, 0, 0, 8'hf0, 8'hff, 0, 0, 0, 0, 0};
    logic [2:0] bsel[11] = '{0, 7, 0, 4, 0, 0, 0, 0, 0, 0, 7};
    logic [7:0] res[11] = '{8'h0f, 8'h8f, 8'h8e, 8'h9e, 8'hfe, 8'h01, 8'h02, 8'h01, 8'hfe,
                            8'hff, 8'h7f};

    io_ports u_dut (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .port_sel(port_sel),
        .port_wr(port_wr), .port_wdata(port_wdata), .rmw_en(rmw_en), .rmw_op(rmw_op),
        .rmw_operand(rmw_operand), .rmw_bit(rmw_bit), .rmw_carry(rmw_carry),
        .read_pin_sel(read_pin_sel), .port_rdata(port_rdata), .rmw_bit_old(rmw_bit_old),
        .bus_active(bus_active), .bus_phase(bus_phase), .bus_page_mode(bus_page_mode),
        .bus_prog_fetch(prog_fetch), .read_strobe_select_cfg(2'h1),
        .addr_width_sel(addr_width_sel),
        .bus_addr(bus_addr), .bus_wdata(8'h96), .bus_rdata(bus_rdata),
        .program_read_strobe_n(prs_n), .data_read_strobe_n(drs_n), .alt_out_a(alt_out_a),
        .alt_out_b(8'hff), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .strong_pullup(strong_pullup));
    pin_partner u_pins (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .ext_low(ext_low),
        .pin_in(pin_in));

    // ------------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ------------------------------------------------------------------
    always #20 clk = ~clk;

    // A hang counts as a failure and still reaches the verdict.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            report_and_stop();
        end
    end

    task automatic tick();
        @(posedge clk);
        #2;
    endtask : tick

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [1:0] p, input logic [7:0] d);
        port_sel = p;
        port_wdata = d;
        port_wr = 1;
        tick();
        port_wr = 0;
        tick();
    endtask : wr

    // Two edges so the registered read data follows the held select.
    task automatic rd_latch(input logic [1:0] p, input logic [7:0] e);
        port_sel = p;
        read_pin_sel = 0;
        tick();
        tick();
        check(port_rdata, e);
    endtask : rd_latch

    task automatic report_and_stop();
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic s_reset();
        for (int p = 0; p < 4; p++) rd_latch(p[1:0], 8'hff);
        check(pin_oe, 0);
        // A write while the clock enable is low must be lost.
        clk_en = 0;
        wr(1, 8'h00);
        clk_en = 1;
        rd_latch(1, 8'hff);
    endtask : s_reset

    // Drive low, release, count the pull-up pulse, then let the alternate output drive.
    task automatic s_write_pullup();
        int cnt = 0;
        wr(1, 8'h00);
        check({pin_oe[15:8], pin_out[15:8]}, 16'hff00);
        rd_latch(1, 8'h00);
        port_wdata = 8'hff;
        port_wr = 1;
        tick();
        port_wr = 0;
        repeat (6) begin
            tick();
            if (strong_pullup[15:8] === 8'hff) cnt++;
        end
        check(cnt, 2);
        check(pin_oe[15:8], 0);
        alt_out_a = 8'h5a;
        tick();
        tick();
        check(pin_in[15:8], 8'h5a);
        alt_out_a = 8'hff;
    endtask : s_write_pullup

    // Pins held low by the board while every operation must work from the latch.
    task automatic s_rmw();
        ext_low[15:8] = 8'hff;
        port_sel = 1;
        read_pin_sel = 1;
        repeat (4) tick();
        check(port_rdata, 8'h00);
        for (int i = 0; i < 11; i++) begin
            rmw_op = ops[i];
            rmw_operand = opd[i];
            rmw_bit = bsel[i];
            rmw_carry = 1;
            rmw_en = 1;
            tick();
            rmw_en = 0;
            rd_latch(1, res[i]);
        end
        // The tested bit follows the latch, which now holds zero in bit 7.
        check(rmw_bit_old, 1'b0);
        ext_low = 0;
    endtask : s_rmw

    // Nonpage then page mode: address placement, read release, latch side effects.
    task automatic s_bus();
        for (int m = 0; m < 2; m++) begin
            wr(0, 8'h00);
            wr(2, 8'h3c);
            bus_active = 1;
            bus_page_mode = m[0];
            prog_fetch = m[0];
            addr_width_sel = m ? 2'h3 : 2'h1;
            bus_addr = 18'h2a5c3;
            bus_phase = BUS_ADDR;
            tick();
            tick();
            check({pin_oe[7:0], pin_out[7:0]}, 16'hffc3);
            check({pin_oe[23:16], pin_out[23:16]}, 16'hffa5);
            check({pin_oe[31], pin_oe[15], pin_out[31], pin_out[15]}, m ? 4'hd : 4'he);
            bus_phase = BUS_WRITE;
            tick();
            tick();
            check({pin_out[23:16], pin_out[7:0]}, m ? 16'h96c3 : 16'ha596);
            // Hold the read long enough for the pin level to pass the synchroniser.
            ext_low = m ? 32'h00a5_0000 : 32'h0000_00ff;
            bus_phase = BUS_READ;
            repeat (4) tick();
            check(m ? pin_oe[23:16] : pin_oe[7:0], 0);
            check(bus_rdata, m ? 8'h5a : 8'h00);
            check({prs_n, drs_n, pin_out[31]}, m ? 3'b010 : 3'b100);
            ext_low = 0;
            bus_active = 0;
            bus_phase = BUS_IDLE;
            tick();
            tick();
            rd_latch(0, 8'hff);
            rd_latch(2, 8'h3c);
            check(pin_oe[7:0], 0);
            check(pin_out[23:16], 8'h3c);
        end
    endtask : s_bus

    // Main sequence after three cycles of reset.
    initial begin
        repeat (3) @(posedge clk);
        #2;
        rst_b = 1;
        s_reset();
        s_write_pullup();
        s_rmw();
        s_bus();
        // A second reset in mid-run must restore every latch.
        rst_b = 0;
        tick();
        rst_b = 1;
        s_reset();
        report_and_stop();
    end
endmodule : tb
